// file: rtl/cpc_chip_protection_control.sv
// chip protection control with boot sequencer and axi4-lite registers
`timescale 1ns/100ps
module cpc_chip_protection_control
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] nvm_guard_image,
  input wire logic [7:0] nvm_boot_image,
  input wire cpc_pkg::cpc_mem_req_s nvm_req,
  input wire cpc_pkg::cpc_mem_req_s eeprom_req,
  input wire logic [7:0] eeprom_rdata_raw,
  output cpc_pkg::cpc_gate_s gate,
  output logic [7:0] eeprom_rdata,
  output logic nvm_refused,
  output logic eeprom_refused,
  output logic early_osc_enable,
  output logic auto_run_user_load,
  output logic ram_wipe_we,
  output logic ram_wipe_iram,
  output logic [11:0] ram_wipe_addr,
  output logic boot_done
);
  // ----------------------------------------
  // protection state
  // ----------------------------------------
  logic [7:0] chip_guard_reg_ff, boot_guard_byte_ff;
  cpc_pkg::cpc_boot_e boot_state_ff;
  logic [11:0] wipe_addr_ff;
  logic [2:0] program_level;
  logic retest_ff, open_ff, run_level, debug_port_kill;
  logic nvm_retest_lock, eeprom_retest_lock, ram_retest_wipe;
  function automatic logic at_run(input logic [2:0] lvl);
    at_run = (lvl[2:1] == cpc_pkg::LVL_RUN[2:1]);
  endfunction
  assign program_level = chip_guard_reg_ff[2:0];
  assign run_level = at_run(program_level);
  assign debug_port_kill = chip_guard_reg_ff[cpc_pkg::CG_DEBUG_KILL];
  // retest flags are honoured only once the part is at run level
  assign nvm_retest_lock = run_level & boot_guard_byte_ff[cpc_pkg::BG_NVM_LOCK];
  assign eeprom_retest_lock = run_level & boot_guard_byte_ff[cpc_pkg::BG_EEPROM_LOCK];
  // wipe is decided in the load cycle, from the images being loaded
  assign ram_retest_wipe = at_run(program_level | nvm_guard_image[2:0])
    & nvm_boot_image[cpc_pkg::BG_RAM_WIPE];

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [11:0] awaddr_ff, rd_addr;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic aw_fire, w_fire, wr_go, rd_fire, wr_guard, wr_ctrl, wr_hit, rd_hit;
  logic [7:0] wbyte, rd_byte;
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == cpc_pkg::CHIP_GUARD_OFS) || (a == cpc_pkg::BOOT_GUARD_OFS)
      || (a == cpc_pkg::BOOT_CTRL_OFS) || (a == cpc_pkg::STATUS_OFS);
  endfunction
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign wr_go = aw_held_ff && w_held_ff;
  assign wbyte = wstrb_ff[0] ? wdata_ff[7:0] : 8'h00;
  assign wr_guard = wr_go && (awaddr_ff == cpc_pkg::CHIP_GUARD_OFS);
  assign wr_ctrl = wr_go && (awaddr_ff == cpc_pkg::BOOT_CTRL_OFS);
  assign wr_hit = reg_hit(awaddr_ff);
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;
  assign rd_hit = reg_hit(rd_addr);
  assign rd_byte =
    (rd_addr == cpc_pkg::CHIP_GUARD_OFS) ? chip_guard_reg_ff :
    (rd_addr == cpc_pkg::BOOT_GUARD_OFS) ? boot_guard_byte_ff :
    (rd_addr == cpc_pkg::STATUS_OFS) ? {5'h00, boot_done, retest_ff, open_ff} :
    8'h00;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 12'h0_000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      aw_held_ff <= wr_go ? 1'b0 : (aw_held_ff | aw_fire);
      w_held_ff <= wr_go ? 1'b0 : (w_held_ff | w_fire);
      if (aw_fire)
        awaddr_ff <= s_axi_awaddr;
      if (w_fire)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= cpc_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= cpc_pkg::RESP_OKAY;
    end
    else
    begin
      if (wr_go)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? cpc_pkg::RESP_OKAY : cpc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_ff <= 1'b0;
      if (rd_fire)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff <= {24'h00_0000, rd_byte};
        rresp_ff <= rd_hit ? cpc_pkg::RESP_OKAY : cpc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // boot sequencer
  // ----------------------------------------
  cpc_pkg::cpc_boot_e nxt_boot_state;
  logic load_now, set_eeprom_block, set_nvm_block, wipe_x_end, wipe_i_end;
  assign load_now = (boot_state_ff == cpc_pkg::BS_LOAD);
  assign wipe_x_end = (wipe_addr_ff == cpc_pkg::WIPE_XRAM_LAST);
  assign wipe_i_end = (wipe_addr_ff[7:0] == cpc_pkg::WIPE_IRAM_LAST);
  assign set_eeprom_block = (boot_state_ff == cpc_pkg::BS_OPEN) && eeprom_retest_lock;
  assign set_nvm_block = (boot_state_ff == cpc_pkg::BS_DONE) && !boot_done
    && retest_ff && nvm_retest_lock;

  always_comb
  begin
    nxt_boot_state = boot_state_ff;
    unique case (boot_state_ff)
      cpc_pkg::BS_IDLE:
        if (wr_ctrl && wbyte[cpc_pkg::BC_START])
          nxt_boot_state = cpc_pkg::BS_LOAD;
      cpc_pkg::BS_LOAD:
        if (!retest_ff)
          nxt_boot_state = cpc_pkg::BS_DONE;
        else if (ram_retest_wipe)
          nxt_boot_state = cpc_pkg::BS_WIPE_X;
        else
          nxt_boot_state = cpc_pkg::BS_OPEN;
      cpc_pkg::BS_WIPE_X:
        if (wipe_x_end)
          nxt_boot_state = cpc_pkg::BS_WIPE_I;
      cpc_pkg::BS_WIPE_I:
        if (wipe_i_end)
          nxt_boot_state = cpc_pkg::BS_OPEN;
      cpc_pkg::BS_OPEN:
        nxt_boot_state = cpc_pkg::BS_DONE;
      cpc_pkg::BS_DONE:
        nxt_boot_state = cpc_pkg::BS_DONE;
      default:
        nxt_boot_state = cpc_pkg::BS_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      boot_state_ff <= cpc_pkg::BS_IDLE;
      retest_ff <= 1'b0;
      open_ff <= 1'b0;
      boot_done <= 1'b0;
      wipe_addr_ff <= 12'h0_000;
    end
    else
    begin
      boot_state_ff <= nxt_boot_state;
      if (boot_state_ff == cpc_pkg::BS_IDLE && wr_ctrl)
        retest_ff <= wbyte[cpc_pkg::BC_RETEST];
      if (boot_state_ff == cpc_pkg::BS_OPEN)
        open_ff <= 1'b1;
      if (boot_state_ff == cpc_pkg::BS_DONE)
        boot_done <= 1'b1;
      // xram from zero up to the factory region, iram above bank 0 bottom
      if (load_now)
        wipe_addr_ff <= 12'h0_000;
      else if (boot_state_ff == cpc_pkg::BS_WIPE_X)
        wipe_addr_ff <= wipe_x_end ? {4'h0, cpc_pkg::WIPE_IRAM_FIRST} : wipe_addr_ff + 12'h0_001;
      else if (boot_state_ff == cpc_pkg::BS_WIPE_I)
        wipe_addr_ff <= wipe_addr_ff + 12'h0_001;
    end
  end

  assign ram_wipe_we = (boot_state_ff == cpc_pkg::BS_WIPE_X) || (boot_state_ff == cpc_pkg::BS_WIPE_I);
  assign ram_wipe_iram = (boot_state_ff == cpc_pkg::BS_WIPE_I);
  assign ram_wipe_addr = wipe_addr_ff;
  assign early_osc_enable = boot_guard_byte_ff[cpc_pkg::BG_OSC_EARLY];
  assign auto_run_user_load = boot_done && (program_level == cpc_pkg::LVL_USER)
    && boot_guard_byte_ff[cpc_pkg::BG_AUTO_RUN];

  // ----------------------------------------
  // guard registers
  // ----------------------------------------
  logic [7:0] nxt_chip_guard, sw_set, boot_set;
  assign sw_set = wr_guard ? (wbyte & cpc_pkg::CG_WMASK) : 8'h00;
  assign boot_set = (set_eeprom_block ? (8'h01 << cpc_pkg::CG_EEPROM_BLOCK) : 8'h00)
    | (set_nvm_block ? (8'h01 << cpc_pkg::CG_NVM_BLOCK) : 8'h00);
  // only ors: no write path can clear a set bit
  assign nxt_chip_guard = chip_guard_reg_ff | sw_set | boot_set
    | (load_now ? ((nvm_guard_image & cpc_pkg::CG_WMASK) | cpc_pkg::CG_RESET) : 8'h00);
  // reset stands for power-on or wake from shutdown, the only clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chip_guard_reg_ff <= cpc_pkg::CG_RESET;
      boot_guard_byte_ff <= cpc_pkg::BG_RESET;
    end
    else
    begin
      chip_guard_reg_ff <= nxt_chip_guard;
      if (load_now)
        boot_guard_byte_ff <= nvm_boot_image & cpc_pkg::BG_WMASK;
    end
  end

  // ----------------------------------------
  // access gating
  // ----------------------------------------
  logic nvm_blk, nvm_wr_blk, eep_blk;
  assign nvm_blk = chip_guard_reg_ff[cpc_pkg::CG_NVM_BLOCK];
  assign nvm_wr_blk = nvm_blk || (run_level && chip_guard_reg_ff[cpc_pkg::CG_NVM_WR_PROT]);
  assign eep_blk = chip_guard_reg_ff[cpc_pkg::CG_EEPROM_BLOCK];
  // fields in declaration order: nvm read, nvm write, eeprom, debug
  assign gate = {!nvm_blk, !nvm_wr_blk, !eep_blk,
    !debug_port_kill && (!retest_ff || open_ff)};
  assign nvm_refused = nvm_req.req && (nvm_req.wr ? nvm_wr_blk : nvm_blk);
  assign eeprom_refused = eeprom_req.req && eep_blk;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      eeprom_rdata <= 8'h00;
    else
      eeprom_rdata <= eep_blk ? 8'h00 : eeprom_rdata_raw;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence guard_write_seq;
    wr_guard && wbyte[cpc_pkg::CG_NVM_BLOCK];
  endsequence
  sticky_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    &(chip_guard_reg_ff | ~$past(chip_guard_reg_ff)))
    else $error("chip guard bit cleared");
  sw_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    guard_write_seq |=> chip_guard_reg_ff[cpc_pkg::CG_NVM_BLOCK])
    else $error("guard write did not set bit");
  nvm_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    nvm_req.req && nvm_blk |-> nvm_refused)
    else $error("nvm access not refused");
  eeprom_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    eep_blk && $past(eep_blk) |-> eeprom_rdata == 8'h00)
    else $error("eeprom read not zero");
  wr_prot_a: assert property (@(posedge aclk) disable iff (!aresetn)
    nvm_req.req && nvm_req.wr && !nvm_blk && !run_level |-> !nvm_refused)
    else $error("write protect used outside run");
  debug_kill_a: assert property (@(posedge aclk) disable iff (!aresetn)
    debug_port_kill |-> !gate.debug_ok)
    else $error("debug open while killed");
  resv_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    chip_guard_reg_ff[cpc_pkg::CG_RESV] && ((boot_guard_byte_ff & ~cpc_pkg::BG_WMASK) == 8'h00))
    else $error("reserved bit changed");
  load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    load_now |=> ((chip_guard_reg_ff & $past(nvm_guard_image) & cpc_pkg::CG_WMASK)
      == ($past(nvm_guard_image) & cpc_pkg::CG_WMASK)))
    else $error("guard not loaded from nvm");
  eep_open_a: assert property (@(posedge aclk) disable iff (!aresetn)
    open_ff && retest_ff && eeprom_retest_lock |-> eep_blk)
    else $error("debug opened before eeprom block");
  auto_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    auto_run_user_load |-> program_level == cpc_pkg::LVL_USER)
    else $error("auto run outside user level");
endmodule // cpc_chip_protection_control

// file: rtl/cpc_pkg.sv
// package for the chip protection control block
package cpc_pkg;
  // register byte addresses on the bus; chip guard keeps its word index
  localparam logic [9:0] CHIP_GUARD_IDX = 10'h0da;
  localparam logic [11:0] CHIP_GUARD_OFS = {CHIP_GUARD_IDX, 2'b00};
  localparam logic [11:0] BOOT_GUARD_OFS = 12'h0_0e0;
  localparam logic [11:0] BOOT_CTRL_OFS = 12'h0_0e4;
  localparam logic [11:0] STATUS_OFS = 12'h0_0e8;
  // chip guard fields
  localparam int CG_NVM_BLOCK = 7;
  localparam int CG_DEBUG_KILL = 6;
  localparam int CG_RESV = 5;
  localparam int CG_EEPROM_BLOCK = 4;
  localparam int CG_NVM_WR_PROT = 3;
  localparam logic [7:0] CG_RESET = 8'h20;
  localparam logic [7:0] CG_WMASK = 8'hdf;
  // boot guard fields
  localparam int BG_NVM_LOCK = 7;
  localparam int BG_EEPROM_LOCK = 6;
  localparam int BG_RAM_WIPE = 5;
  localparam int BG_OSC_EARLY = 4;
  localparam int BG_AUTO_RUN = 1;
  localparam logic [7:0] BG_RESET = 8'h00;
  localparam logic [7:0] BG_WMASK = 8'hf2;
  // program levels
  localparam logic [2:0] LVL_FACTORY = 3'b001;
  localparam logic [2:0] LVL_USER = 3'b011;
  localparam logic [2:0] LVL_RUN = 3'b111;
  // boot control bits
  localparam int BC_START = 0;
  localparam int BC_RETEST = 1;
  localparam int BC_DONE = 2;
  // ram wipe geometry
  localparam logic [7:0] WIPE_IRAM_FIRST = 8'h08;
  localparam logic [7:0] WIPE_IRAM_LAST = 8'hff;
  localparam logic [11:0] WIPE_XRAM_LAST = 12'heff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0]
  {
    BS_IDLE = 3'b000,
    BS_LOAD = 3'b001,
    BS_WIPE_X = 3'b010,
    BS_WIPE_I = 3'b011,
    BS_OPEN = 3'b100,
    BS_DONE = 3'b101
  } cpc_boot_e;
  typedef struct packed
  {
    logic req;
    logic wr;
    logic [11:0] addr;
  } cpc_mem_req_s;
  typedef struct packed
  {
    logic nvm_rd_ok;
    logic nvm_wr_ok;
    logic eeprom_ok;
    logic debug_ok;
  } cpc_gate_s;
endpackage

// file: tb/cpc_chip_protection_control_bench.sv
// self-checking bench for the chip protection control block
`timescale 1ns/100ps
module cpc_chip_protection_control_bench;
  // ----------------------------------------
  // signals and shorthands
  // ----------------------------------------
  localparam logic [11:0] CG = cpc_pkg::CHIP_GUARD_OFS;
  localparam logic [11:0] BG = cpc_pkg::BOOT_GUARD_OFS;
  localparam logic [1:0] OK = cpc_pkg::RESP_OKAY;
  localparam logic [1:0] SE = cpc_pkg::RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0_000;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h0_000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [7:0] nvm_guard_image = 8'h00;
  logic [7:0] nvm_boot_image = 8'h00;
  cpc_pkg::cpc_mem_req_s nvm_req = '0;
  cpc_pkg::cpc_mem_req_s eeprom_req = '0;
  logic [7:0] eeprom_rdata_raw = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  cpc_pkg::cpc_gate_s gate;
  logic [7:0] eeprom_rdata;
  logic nvm_refused, eeprom_refused, early_osc_enable, auto_run_user_load;
  logic ram_wipe_we, ram_wipe_iram, boot_done;
  logic [11:0] ram_wipe_addr;
  logic [11:0] i_first;
  logic [33:0] note;
  logic [33:0] exp_q[$];
  logic [7:0] e, v;
  logic [7:0] gi [3] = '{8'h01, 8'h03, 8'h07};
  logic [7:0] bi [3] = '{8'h13, 8'hef, 8'hf2};
  logic au [3] = '{1'b0, 1'b1, 1'b0};
  int miscompares = 0;
  int n_checks = 0;
  int x_n, i_n, i;
  integer seed = 28007;

  always #50 aclk = ~aclk;

  cpc_chip_protection_control uut
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .nvm_guard_image(nvm_guard_image), .nvm_boot_image(nvm_boot_image),
    .nvm_req(nvm_req), .eeprom_req(eeprom_req), .eeprom_rdata_raw(eeprom_rdata_raw),
    .gate(gate), .eeprom_rdata(eeprom_rdata), .nvm_refused(nvm_refused),
    .eeprom_refused(eeprom_refused), .early_osc_enable(early_osc_enable),
    .auto_run_user_load(auto_run_user_load), .ram_wipe_we(ram_wipe_we),
    .ram_wipe_iram(ram_wipe_iram), .ram_wipe_addr(ram_wipe_addr), .boot_done(boot_done)
  );

  // ----------------------------------------
  // compare, bus and boot tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic [31:0] rnd;
    logic ah, wh, ad, wd;
    @(posedge aclk);
    rnd = $random(seed);
    exp_q.push_back({r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {rnd[31:8], d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd))
    begin
      @(negedge aclk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      if (ah)
        s_axi_awvalid <= 1'b0;
      if (wh)
        s_axi_wvalid <= 1'b0;
      ad |= ah;
      wd |= wh;
    end
    ah = 1'b0;
    while (!ah)
    begin
      @(negedge aclk);
      ah = s_axi_bvalid;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic h;
    @(posedge aclk);
    exp_q.push_back({r, 24'h00_0000, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    h = 1'b0;
    while (!h)
    begin
      @(negedge aclk);
      h = s_axi_arvalid & s_axi_arready;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    h = 1'b0;
    while (!h)
    begin
      @(negedge aclk);
      h = s_axi_rvalid;
      @(posedge aclk);
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic boot(input logic [7:0] g, input logic [7:0] b, input logic rt);
    int n;
    @(posedge aclk);
    nvm_guard_image <= g;
    nvm_boot_image <= b;
    wr(cpc_pkg::BOOT_CTRL_OFS, {6'h00, rt, 1'b1}, OK);
    n = 0;
    while (boot_done !== 1'b1 && n < 6000)
    begin
      @(negedge aclk);
      n++;
    end
    chk(boot_done, 1);
  endtask

  // ----------------------------------------
  // response monitor and wipe counter
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
    begin
      note = exp_q.pop_front();
      chk(s_axi_bresp, note[33:32]);
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
    begin
      note = exp_q.pop_front();
      chk(s_axi_rresp, note[33:32]);
      chk(s_axi_rdata, note[31:0]);
    end
  end

  always @(posedge aclk)
    if (!aresetn)
    begin
      x_n <= 0;
      i_n <= 0;
    end
    else if (ram_wipe_we === 1'b1)
    begin
      if (ram_wipe_iram && i_n == 0)
        i_first <= ram_wipe_addr;
      if (ram_wipe_iram)
        i_n <= i_n + 1;
      else
        x_n <= x_n + 1;
    end

  initial
  begin
    #(30000 * 100);
    miscompares++;
    conclude();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    rst();
    rd(CG, 8'h20, OK);
    rd(12'h1_00, 8'h00, SE);
    wr(12'h1_00, 8'hff, SE);
    wr(BG, 8'hff, OK);
    rd(BG, 8'h00, OK);
    e = 8'h20;
    for (i = 0; i < 6; i++)
    begin
      v = (i == 5) ? 8'h00 : 8'($random(seed));
      wr(CG, v, OK);
      e = e | (v & 8'hdf);
      rd(CG, e, OK);
      @(negedge aclk);
      chk(gate.nvm_rd_ok, !e[7]);
      chk(gate.eeprom_ok, !e[4]);
      chk(gate.debug_ok, !e[6]);
      chk(gate.nvm_wr_ok, !(e[7] | (e[3] & e[2] & e[1])));
    end
    rst();
    wr(CG, 8'h0a, OK);
    @(posedge aclk);
    nvm_req <= '{req: 1'b1, wr: 1'b1, addr: 12'h0_040};
    eeprom_req <= '{req: 1'b1, wr: 1'b0, addr: 12'h0_003};
    eeprom_rdata_raw <= 8'h5a;
    @(posedge aclk);
    @(negedge aclk);
    chk(nvm_refused, 0);
    chk(eeprom_rdata, 8'h5a);
    wr(CG, 8'h14, OK);
    @(negedge aclk);
    chk(nvm_refused, 1);
    chk(eeprom_rdata, 8'h00);
    chk(eeprom_refused, 1);
    @(posedge aclk);
    nvm_req <= '{req: 1'b1, wr: 1'b0, addr: 12'h0_040};
    @(negedge aclk);
    chk(nvm_refused, 0);
    wr(CG, 8'h80, OK);
    @(negedge aclk);
    chk(nvm_refused, 1);
    for (i = 0; i < 3; i++)
    begin
      rst();
      boot(gi[i], bi[i], 1'b0);
      rd(CG, gi[i] | 8'h20, OK);
      rd(BG, bi[i] & 8'hf2, OK);
      @(negedge aclk);
      chk(early_osc_enable, bi[i][4]);
      chk(auto_run_user_load, au[i]);
    end
    rst();
    boot(8'h07, 8'he0, 1'b1);
    chk(x_n, 3840);
    chk(i_n, 248);
    chk(i_first, 12'h0_008);
    rd(CG, 8'hb7, OK);
    rd(cpc_pkg::STATUS_OFS, 8'h07, OK);
    @(negedge aclk);
    chk(gate.debug_ok, 1);
    chk(gate.eeprom_ok, 0);
    chk(gate.nvm_rd_ok, 0);
    rst();
    rd(CG, 8'h20, OK);
    boot(8'h03, 8'he0, 1'b1);
    chk(x_n + i_n, 0);
    rd(CG, 8'h23, OK);
    wr(CG, 8'h40, OK);
    @(negedge aclk);
    chk(gate.debug_ok, 0);
    rst();
    rd(CG, 8'h20, OK);
    conclude();
  end
endmodule // cpc_chip_protection_control_bench
